// ---- dcs_pkg.sv ----
package dcs_pkg;

  // Command codes presented by the memory controller
  typedef enum logic [3:0] {
    DCS_NOP,
    DCS_ACT,
    DCS_PRE,
    DCS_PREA,
    DCS_REF,
    DCS_RD,
    DCS_RDA,
    DCS_WR,
    DCS_WRA,
    DCS_MRS,
    DCS_SYNC,
    DCS_DES
  } dcs_cmd_e;

  typedef enum logic {
    DCS_G2666,
    DCS_G3200
  } dcs_grade_e;

  localparam int CLK_PERIOD_PS        = 10000;
  localparam int ACT_PDEN_NCK         = 2;
  localparam int PRE_PDEN_NCK         = 2;
  localparam int REF_PDEN_NCK         = 2;
  localparam int RD_PDEN_ADD          = 5;
  localparam int WR_BURST_ADD         = 4;
  localparam int WR_BC4MRS_ADD        = 2;
  localparam int WRA_EXTRA            = 1;
  localparam int MRD_PDA_NCK          = 16;
  localparam int MRD_PDA_PS           = 10000;
  localparam int MRD_PDA_CYC          = (MRD_PDA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MRD_PDA_MIN          = (MRD_PDA_NCK > MRD_PDA_CYC) ? MRD_PDA_NCK : MRD_PDA_CYC;
  localparam int SYNC_GEAR_ADD        = 4;
  localparam int PAR_PW_MIN_2666      = 80;
  localparam int PAR_PW_MAX_2666      = 160;
  localparam int PAR_PW_MIN_3200      = 96;
  localparam int PAR_PW_MAX_3200      = 192;
  localparam int PAR_RSP_2666         = 71;
  localparam int PAR_RSP_3200         = 85;
  localparam int PL_2666              = 5;
  localparam int PL_3200              = 6;
  localparam int CRC_PW_MIN           = 6;
  localparam int CRC_PW_MAX           = 10;
  localparam int CNT_W                = 8;

endpackage : dcs_pkg

// ---- dcs_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Countdown request and status between checker and its timers
interface dcs_tmr_if #(parameter int W = 8);
  logic         load;
  logic [W-1:0] value;
  logic         done;
  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface : dcs_tmr_if
`default_nettype wire

// ---- dcs_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
// Reloadable down counter; a load keeps the larger of remaining and new
module dcs_timer #(
  parameter int W = 8
) (
  input  wire logic clk,
  input  wire logic srst,
  dcs_tmr_if.tmr    t
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  always_comb
  begin
    next_cnt = cnt;
    if (t.load && t.value > cnt)
      next_cnt = t.value;
    else if (cnt != '0)
      next_cnt = cnt - W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  assign t.done = (cnt == '0);
endmodule : dcs_timer
`default_nettype wire

// ---- ddr_cmd_spacing_checker.sv ----
// Behaviour
// - ACT, PRE, REF: 2 cycles before power-down
// - Read: RL+4+1 cycles before power-down
// - Write: WL+4+tWR cycles, BC4 fixed uses 2
// - Write-autoprecharge: WL+4+WR+1, BC4 fixed uses 2
// - MRS: tMOD before power-down entry
// - PDA: MRS spacing max of 16nCK,10ns
// - PDA: tMOD after MRS before other command
// - Persistent parity: deselects within 71/85 cycles
// - Gear-down: sync pulse after tMOD+4 cycles
// - After sync, tMOD before first command
// - Gear-down delays rounded to even cycles
// - tWR converted to cycles rounding upward
// - CKE low allowed during internal operations
`timescale 1ns/1ps
`default_nettype none
module ddr_cmd_spacing_checker
  import dcs_pkg::*;
#(
  parameter int W = dcs_pkg::CNT_W
) (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire dcs_pkg::dcs_cmd_e    cmd,
  input  wire logic                 cmd_valid,
  input  wire dcs_pkg::dcs_grade_e  grade,
  input  wire logic                 bc4_fixed,
  input  wire logic                 pda_mode,
  input  wire logic                 gear_down_en,
  input  wire logic                 persist_parity,
  input  wire logic [5:0]           rl,
  input  wire logic [5:0]           wl,
  input  wire logic [5:0]           wr_prog,
  input  wire logic [15:0]          twr_ps,
  input  wire logic [5:0]           tmod,
  input  wire logic                 alert_n,
  output var  logic                 pd_allowed,
  output var  logic                 mrs_allowed,
  output var  logic                 cmd_allowed,
  output var  logic                 sync_allowed,
  output var  logic                 des_required,
  output var  logic                 par_alert,
  output var  logic                 crc_alert,
  output var  logic                 alert_width_err,
  output var  logic                 spacing_err
);
  import dcs_pkg::*;

  // Elaboration check: counters must hold the longest alert width
  if (W < 8)
  begin : g_w_chk
    $error("W too narrow for 192-cycle alert width");
  end

  // Timers: 0 power-down, 1 MRS spacing, 2 non-MRS command, 3 sync
  localparam int NT = 4;
  dcs_tmr_if #(.W(W)) tif [NT] ();
  logic [NT-1:0] done;

  genvar g;
  generate
    for (g = 0; g < NT; g++)
    begin : g_tmr
      dcs_timer #(.W(W)) u_tmr (.clk(clk), .srst(srst), .t(tif[g]));
      assign done[g] = tif[g].done;
    end
  endgenerate

  logic         go;
  logic [W-1:0] twr_cyc;
  logic [W-1:0] wr_add;
  logic [W-1:0] pd_val;
  logic [W-1:0] tmod_even;
  logic [W-1:0] sync_val;
  logic [19:0]  twr_sum;

  always_comb
  begin
    go        = cmd_valid && cmd != DCS_NOP && cmd != DCS_DES;
    twr_sum   = 20'(twr_ps) + 20'(CLK_PERIOD_PS - 1);
    twr_cyc   = W'(twr_sum / 20'(CLK_PERIOD_PS));
    wr_add    = bc4_fixed ? W'(WR_BC4MRS_ADD) : W'(WR_BURST_ADD);
    tmod_even = W'(tmod) + W'(tmod[0]);
    sync_val  = W'(tmod) + W'(SYNC_GEAR_ADD);
    sync_val  = sync_val + W'(sync_val[0]);
    pd_val    = '0;
    unique case (cmd)
      DCS_ACT:              pd_val = W'(ACT_PDEN_NCK);
      DCS_PRE, DCS_PREA:    pd_val = W'(PRE_PDEN_NCK);
      DCS_REF:              pd_val = W'(REF_PDEN_NCK);
      DCS_RD, DCS_RDA:      pd_val = W'(rl) + W'(RD_PDEN_ADD);
      DCS_WR:               pd_val = W'(wl) + wr_add + twr_cyc;
      DCS_WRA:              pd_val = W'(wl) + wr_add + W'(wr_prog) + W'(WRA_EXTRA);
      DCS_MRS:              pd_val = W'(tmod);
      default:              pd_val = '0;
    endcase
  end

  assign tif[0].load  = go;
  assign tif[0].value = pd_val;
  assign tif[1].load  = go && cmd == DCS_MRS && pda_mode;
  assign tif[1].value = W'(MRD_PDA_MIN);
  assign tif[2].load  = go && ((cmd == DCS_MRS && pda_mode) || cmd == DCS_SYNC);
  assign tif[2].value = (cmd == DCS_SYNC) ? tmod_even : W'(tmod);
  assign tif[3].load  = go && cmd == DCS_MRS && gear_down_en;
  assign tif[3].value = sync_val;

  // Alert decoding: width classifies parity (long) versus CRC (short)
  logic [W-1:0] lo_cnt;
  logic [W-1:0] next_lo_cnt;
  logic [W-1:0] rsp_cnt;
  logic [W-1:0] next_rsp_cnt;
  logic         alert_q;
  logic         next_pd, next_mrs, next_cmd, next_sync, next_des;
  logic         next_par, next_crc, next_werr, next_serr;
  logic [W-1:0] pw_min, pw_max, rsp_max;

  always_comb
  begin
    pw_min  = (grade == DCS_G3200) ? W'(PAR_PW_MIN_3200) : W'(PAR_PW_MIN_2666);
    pw_max  = (grade == DCS_G3200) ? W'(PAR_PW_MAX_3200) : W'(PAR_PW_MAX_2666);
    rsp_max = (grade == DCS_G3200) ? W'(PAR_RSP_3200) : W'(PAR_RSP_2666);
    next_lo_cnt  = alert_n ? '0 : ((lo_cnt == '1) ? lo_cnt : lo_cnt + W'(1));
    next_rsp_cnt = rsp_cnt;
    next_par     = 1'b0;
    next_crc     = 1'b0;
    next_werr    = 1'b0;
    next_des     = des_required;
    if (!alert_n && alert_q)
      next_rsp_cnt = '0;
    else if (!alert_n && rsp_cnt != '1)
      next_rsp_cnt = rsp_cnt + W'(1);
    if (persist_parity && !alert_n && lo_cnt == W'(CRC_PW_MAX))
      next_des = 1'b1;
    if (persist_parity && !alert_n && rsp_cnt + W'(2) >= rsp_max)
      next_des = 1'b1;
    if (alert_n)
      next_des = 1'b0;
    if (alert_n && !alert_q)
    begin
      if (lo_cnt >= W'(CRC_PW_MIN) && lo_cnt <= W'(CRC_PW_MAX))
        next_crc = 1'b1;
      else if (lo_cnt >= pw_min && lo_cnt <= pw_max)
        next_par = 1'b1;
      else
        next_werr = 1'b1;
    end
    next_pd   = done[0] && !go;
    next_mrs  = done[1] && !(go && cmd == DCS_MRS && pda_mode);
    next_cmd  = done[2] && !tif[2].load;
    next_sync = done[3] && !tif[3].load;
    next_serr = go && ((cmd == DCS_MRS && pda_mode && !done[1])
                || (cmd == DCS_SYNC && !done[3])
                || (cmd != DCS_MRS && cmd != DCS_SYNC && !done[2]));
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      lo_cnt          <= '0;
      rsp_cnt         <= '0;
      alert_q         <= 1'b1;
      pd_allowed      <= 1'b0;
      mrs_allowed     <= 1'b0;
      cmd_allowed     <= 1'b0;
      sync_allowed    <= 1'b0;
      des_required    <= 1'b0;
      par_alert       <= 1'b0;
      crc_alert       <= 1'b0;
      alert_width_err <= 1'b0;
      spacing_err     <= 1'b0;
    end
    else
    begin
      lo_cnt          <= next_lo_cnt;
      rsp_cnt         <= next_rsp_cnt;
      alert_q         <= alert_n;
      pd_allowed      <= next_pd;
      mrs_allowed     <= next_mrs;
      cmd_allowed     <= next_cmd;
      sync_allowed    <= next_sync;
      des_required    <= next_des;
      par_alert       <= next_par;
      crc_alert       <= next_crc;
      alert_width_err <= next_werr;
      spacing_err     <= next_serr;
    end
  end
endmodule : ddr_cmd_spacing_checker
`default_nettype wire

// ---- dcs_chk_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcs_chk_properties
  import dcs_pkg::*;
(
  input wire logic              clk,
  input wire logic              srst,
  input wire dcs_pkg::dcs_cmd_e cmd,
  input wire logic              cmd_valid,
  input wire logic              pda_mode,
  input wire logic              gear_down_en,
  input wire logic              persist_parity,
  input wire logic [5:0]        wl,
  input wire logic [5:0]        tmod,
  input wire logic              alert_n,
  input wire logic              pd_allowed,
  input wire logic              mrs_allowed,
  input wire logic              cmd_allowed,
  input wire logic              sync_allowed,
  input wire logic              des_required,
  input wire logic              par_alert,
  input wire logic              crc_alert
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_ROW_PD: assert property (cmd_valid && cmd inside {DCS_ACT, DCS_PRE, DCS_PREA, DCS_REF} |=> !pd_allowed [*2])
    else $error("power-down open early after row command");
  AST_RD_PD: assert property (cmd_valid && cmd inside {DCS_RD, DCS_RDA} |=> !pd_allowed [*5])
    else $error("power-down open early after read");
  AST_WR_PD: assert property (cmd_valid && cmd inside {DCS_WR, DCS_WRA} && wl > 6'h05 |=> !pd_allowed [*8])
    else $error("power-down open early after write");
  AST_MRS_PD: assert property (cmd_valid && cmd == DCS_MRS && tmod != 6'h00 |=> !pd_allowed)
    else $error("power-down open right after mode set");
  AST_PDA_MRS: assert property (cmd_valid && cmd == DCS_MRS && pda_mode |=> !mrs_allowed [*8] ##1 !mrs_allowed [*8])
    else $error("mode set spacing short in per-device mode");
  AST_PDA_CMD: assert property (cmd_valid && cmd == DCS_MRS && pda_mode && tmod != 6'h00 |=> !cmd_allowed)
    else $error("command open right after per-device mode set");
  AST_SYNC: assert property (cmd_valid && cmd == DCS_MRS && gear_down_en |=> !sync_allowed [*4])
    else $error("sync open too soon");
  AST_SYNC_CMD: assert property (cmd_valid && cmd == DCS_SYNC && tmod != 6'h00 |=> !cmd_allowed [*2])
    else $error("command open too soon after sync");
  AST_CRC: assert property (crc_alert |-> $past(alert_n) && !$past(alert_n, 2) && !$past(alert_n, 7) && $past(alert_n, 12))
    else $error("crc alert on wrong width");
  AST_PAR: assert property (par_alert |-> $past(alert_n) && !$past(alert_n, 81) && $past(alert_n, 194))
    else $error("parity alert on wrong width");
  AST_DES: assert property ($fell(alert_n) && persist_parity ##1 !alert_n [*8] ##1 !alert_n [*8] |-> des_required)
    else $error("deselects not demanded");
endmodule : dcs_chk_properties
bind ddr_cmd_spacing_checker dcs_chk_properties u_chk (.*);
`default_nettype wire

// ---- dcs_dram_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcs_dram_model
  import dcs_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                par_err,
  input  wire logic                crc_err,
  input  wire dcs_pkg::dcs_grade_e grade,
  output var  logic                alert_n
);
  int cnt = 0;
  always_ff @(posedge clk)
  begin
    if (par_err)
      cnt <= (grade == DCS_G3200) ? PAR_PW_MIN_3200 : PAR_PW_MIN_2666;
    else if (crc_err)
      cnt <= CRC_PW_MIN + 2;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  assign alert_n = (cnt == 0);
endmodule : dcs_dram_model
`default_nettype wire

// ---- test_ddr_cmd_spacing_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_ddr_cmd_spacing_checker;
  import dcs_pkg::*;
  logic       clk = 0, srst = 1, cmd_valid = 0, bc4 = 0, pda = 0, gear = 0, pers = 0, par_err = 0, crc_err = 0;
  dcs_cmd_e   cmd = DCS_NOP;
  dcs_grade_e grade = DCS_G2666;
  logic       alert_n, pd_ok, mrs_ok, cmd_ok, sync_ok, des, par_a, crc_a, werr, serr;
  int         err_count = 0, check_count = 0;
  initial forever #5 clk = ~clk;
  ddr_cmd_spacing_checker dut (.clk(clk), .srst(srst), .cmd(cmd), .cmd_valid(cmd_valid), .grade(grade),
    .bc4_fixed(bc4), .pda_mode(pda), .gear_down_en(gear), .persist_parity(pers), .rl(6'h0A), .wl(6'h09),
    .wr_prog(6'h0C), .twr_ps(16'h3A98), .tmod(6'h05), .alert_n(alert_n), .pd_allowed(pd_ok),
    .mrs_allowed(mrs_ok), .cmd_allowed(cmd_ok), .sync_allowed(sync_ok), .des_required(des),
    .par_alert(par_a), .crc_alert(crc_a), .alert_width_err(werr), .spacing_err(serr));
  dcs_dram_model dram (.clk(clk), .par_err(par_err), .crc_err(crc_err), .grade(grade), .alert_n(alert_n));
  task chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk
  task conclude;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  function logic flag(input int sel);
    return sel == 0 ? pd_ok : sel == 1 ? mrs_ok : sel == 2 ? cmd_ok : sync_ok;
  endfunction : flag
  // Second command is taken one edge later; count from that edge
  task run(input dcs_cmd_e c1, input dcs_cmd_e c2, input int sel, input logic [7:0] exp);
    int n;
    repeat (40) @(posedge clk);
    cmd <= c1;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd <= c2;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    n = 0;
    while (flag(sel) !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("spacing", n, exp);
  endtask : run
  // Second per-device mode set one cycle after the first must be flagged
  task mrs_back_to_back;
    repeat (40) @(posedge clk);
    cmd <= DCS_MRS;
    cmd_valid <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk("spacing_err", serr, 1);
    @(posedge clk);
    #1;
    chk("spacing_err_pulse", serr, 0);
  endtask : mrs_back_to_back
  task alert(input logic par, input dcs_grade_e g);
    int   n;
    logic seen, d, w;
    seen = 0;
    d = 0;
    w = 0;
    grade <= g;
    pers <= par;
    @(posedge clk);
    par_err <= par;
    crc_err <= !par;
    @(posedge clk);
    par_err <= 1'b0;
    crc_err <= 1'b0;
    for (n = 0; n < 250 && !seen; n++)
    begin
      @(posedge clk);
      #1;
      d = d | des;
      w = w | werr;
      seen = par ? par_a : crc_a;
    end
    chk("alert_class", seen, 1);
    chk("deselect", d, par);
    chk("alert_width_err", w, 0);
  endtask : alert
  initial
  begin
    repeat (12) @(posedge clk);
    chk("pd_in_reset", pd_ok, 0);
    srst <= 1'b0;
    run(DCS_ACT, DCS_NOP, 0, 2);
    run(DCS_PRE, DCS_NOP, 0, 2);
    run(DCS_PREA, DCS_NOP, 0, 2);
    run(DCS_REF, DCS_NOP, 0, 2);
    run(DCS_RD, DCS_NOP, 0, 15);
    run(DCS_RDA, DCS_NOP, 0, 15);
    run(DCS_WR, DCS_NOP, 0, 15);
    run(DCS_WRA, DCS_NOP, 0, 26);
    run(DCS_ACT, DCS_RD, 0, 16);
    run(DCS_WRA, DCS_ACT, 0, 26);
    run(DCS_MRS, DCS_NOP, 0, 5);
    bc4 <= 1'b1;
    run(DCS_WR, DCS_NOP, 0, 13);
    run(DCS_WRA, DCS_NOP, 0, 24);
    pda <= 1'b1;
    run(DCS_MRS, DCS_NOP, 1, 16);
    run(DCS_MRS, DCS_NOP, 2, 5);
    mrs_back_to_back();
    pda <= 1'b0;
    gear <= 1'b1;
    run(DCS_MRS, DCS_NOP, 3, 10);
    gear <= 1'b0;
    run(DCS_SYNC, DCS_NOP, 2, 6);
    alert(1'b0, DCS_G2666);
    alert(1'b1, DCS_G2666);
    alert(1'b1, DCS_G3200);
    conclude();
  end
endmodule : test_ddr_cmd_spacing_checker
`default_nettype wire
